// ### verilog/dli_pkg.sv
// constants shared by the die link initiator control/status bank and its clock divider
// assumes byte wide register port with three byte offsets and one bus clock domain
// Function
// - link_enable turns initiator on; write-once normally, always writable in special modes
// - once enabled, active data lines driven low as idle; link clock is divided bus clock
// - while disabled, no link line is used; pins revert to general purpose
// - lane_width_sel 0 uses lines 3..0 only; 1 uses all eight lines
// - after enabling in normal mode, writes to enable, width, divider, wait limit ignored
// - halt_in_wait 1 stops link clock in wait mode; writable at any time
// - divider codes 00,01,10,11 divide bus clock by 1,2,3,4
// - link clock high phase at most half the period; shorter for odd ratios
// - target interrupt forwarded only while target_irq_enable is 1
// - wait limit 0000 expects acknowledge in the link cycle right after transfer
// - limit 1..15 allows that many wait cycles; beyond that a timeout is declared
// - acknowledge timeout sets read-only ack_timeout_flag in status register 0
// - error_summary_flag set when any error flag set; raises unmasked interrupt
// - writing 1 clears error_summary_flag; writing 0 leaves it
// - clearing summary clears the five error flags; those flags are not writable
// - ack_line_fault_flag set if any active data input is low in acknowledge cycle
// - while summary pending, new transactions cancelled, idle sent, cancel_flag set
// - target_error_flag set when target error seen in acknowledge cycle
// - parity_fault_flag set on received parity error
// - two received parity bits readable in status bits 1 and 0
// - reset leaves link disabled; software configures before enabling
// - link clock held low when disabled, stopped, or waiting with halt_in_wait

package dli_pkg;
    localparam logic [2:0] OFS_CTRL0 = 3'h0;
    localparam logic [2:0] OFS_CTRL1 = 3'h1;
    localparam logic [2:0] OFS_STAT0 = 3'h2;

    // control 0 fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_WIDTH = 6;
    localparam int BIT_HALT_WAIT = 5;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 2;
    // control 1 fields
    localparam int BIT_IRQ_EN = 7;
    localparam int LIMIT_LSB = 0;
    localparam int LIMIT_W = 4;
    // status 0 fields
    localparam int BIT_ERR_SUM = 7;
    localparam int BIT_ACK_FAULT = 6;
    localparam int BIT_CANCEL = 5;
    localparam int BIT_TIMEOUT = 4;
    localparam int BIT_TGT_ERR = 3;
    localparam int BIT_PARITY = 2;
    localparam int PAR_LSB = 0;
    localparam int PAR_W = 2;

    localparam int LANES = 8;
    localparam logic [LANES-1:0] MASK_NARROW = 8'h0f;
    localparam logic [LANES-1:0] MASK_WIDE = 8'hff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [LIMIT_W-1:0] RST_LIMIT = 4'h0;
    localparam logic [DIV_W-1:0] RST_DIV = 2'h0;

    typedef enum logic [2:0] {
        DLI_WAIT_IDLE = 3'b001,
        DLI_WAIT_ACK = 3'b010,
        DLI_WAIT_DONE = 3'b100
    } dli_wait_t;
endpackage : dli_pkg

// ### verilog/dli_clkdiv.sv
// link clock generator: divides the bus clock by code+1
// assumes run is a same-domain level; stops only at the end of a period
`timescale 1ns/1ps
`default_nettype none
module dli_clkdiv
    import dli_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [DIV_W-1:0] div_code,
    output logic link_clk,
    output logic tick
);
    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic clk_q, clk_d;
    logic tick_q, tick_d;
    logic run1_q, run1_d;
    logic [DIV_W-1:0] high_len;

    always_comb begin
        // high phase is floor(ratio/2) cycles, so odd ratios get the short high
        high_len = DIV_W'(((DIV_W + 1)'(div_code) + (DIV_W + 1)'(1)) >> 1);
        cnt_d = cnt_q;
        clk_d = 1'b0;
        tick_d = 1'b0;
        run1_d = run && (div_code == RST_DIV);
        if (cnt_q != 2'h0) begin
            cnt_d = (cnt_q == div_code) ? 2'h0 : cnt_q + 2'h1;
        end else if (run && div_code != RST_DIV) begin
            cnt_d = 2'h1;
            tick_d = 1'b1;
        end else if (run) begin
            tick_d = 1'b1;
        end
        if (cnt_d < high_len && (cnt_d != 2'h0 || (run && cnt_q == div_code))) begin
            clk_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 2'h0;
            clk_q <= 1'b0;
            tick_q <= 1'b0;
            run1_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
            tick_q <= tick_d;
            run1_q <= run1_d;
        end
    end

    // divide by one cannot come from a flop; the bus clock is gated instead
    assign link_clk = run1_q ? clk : clk_q;
    assign tick = tick_q;
endmodule : dli_clkdiv
`default_nettype wire

// ### verilog/dli_ctrl_status.sv
// control and status register bank of the die link initiator
// assumes a byte register port on the bus clock and an outside transaction engine
`timescale 1ns/1ps
`default_nettype none
module dli_ctrl_status
    import dli_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic special_mode,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic xact_req,
    input wire logic last_xfer,
    input wire logic ack_seen,
    input wire logic target_err,
    input wire logic parity_err,
    input wire logic [PAR_W-1:0] rx_parity,
    input wire logic eng_drive,
    input wire logic [LANES-1:0] eng_data,
    input wire logic [LANES-1:0] link_data_in,
    input wire logic target_irq_input,
    output logic [LANES-1:0] link_data_out,
    output logic [LANES-1:0] link_data_oe,
    output logic link_clock_out,
    output logic link_clock_oe,
    output logic pins_primary,
    output logic xact_go,
    output logic xact_cancel,
    output logic ack_done,
    output logic target_irq_out,
    output logic error_irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    logic enable_q, enable_d;
    logic width_q, width_d;
    logic halt_wait_q, halt_wait_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic irq_en_q, irq_en_d;
    logic [LIMIT_W-1:0] limit_q, limit_d;
    logic unlocked;
    logic wr_ctl0, wr_ctl1, wr_stat0;

    function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] ofs);
        return addr == ofs;
    endfunction : reg_hit

    always_comb begin
        wr_ctl0 = reg_wr && reg_hit(reg_addr, OFS_CTRL0);
        wr_ctl1 = reg_wr && reg_hit(reg_addr, OFS_CTRL1);
        wr_stat0 = reg_wr && reg_hit(reg_addr, OFS_STAT0);
        unlocked = !enable_q || special_mode;
        enable_d = enable_q;
        width_d = width_q;
        halt_wait_d = halt_wait_q;
        div_d = div_q;
        irq_en_d = irq_en_q;
        limit_d = limit_q;
        if (wr_ctl0) begin
            halt_wait_d = reg_wdata[BIT_HALT_WAIT];
            if (unlocked) begin
                enable_d = reg_wdata[BIT_ENABLE];
                width_d = reg_wdata[BIT_WIDTH];
                div_d = reg_wdata[DIV_LSB +: DIV_W];
            end
        end
        if (wr_ctl1) begin
            irq_en_d = reg_wdata[BIT_IRQ_EN];
            if (unlocked) begin
                limit_d = reg_wdata[LIMIT_LSB +: LIMIT_W];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_q <= 1'b0;
            width_q <= 1'b0;
            halt_wait_q <= 1'b0;
            div_q <= RST_DIV;
            irq_en_q <= 1'b0;
            limit_q <= RST_LIMIT;
        end else begin
            enable_q <= enable_d;
            width_q <= width_d;
            halt_wait_q <= halt_wait_d;
            div_q <= div_d;
            irq_en_q <= irq_en_d;
            limit_q <= limit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // pins are asynchronous, so nothing but the second stage reads the first
    logic [LANES-1:0] din_s1_q, din_s2_q;
    logic irq_s1_q, irq_s2_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            din_s1_q <= RST_BYTE;
            din_s2_q <= RST_BYTE;
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
        end else begin
            din_s1_q <= link_data_in;
            din_s2_q <= din_s1_q;
            irq_s1_q <= target_irq_input;
            irq_s2_q <= irq_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link clock
    logic run;
    logic tick;

    // halting waits for the current period to end inside the divider
    assign run = enable_q && !stop_mode && !(wait_mode && halt_wait_q);

    dli_clkdiv u_div (
        .clk(clk),
        .srst(srst),
        .run(run),
        .div_code(div_q),
        .link_clk(link_clock_out),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // acknowledge wait supervision, counted in link clock periods
    // limit counts extra ticks, so limit zero accepts only the first tick
    dli_wait_t wst_q, wst_d;
    logic [LIMIT_W-1:0] wcnt_q, wcnt_d;
    logic ack_cyc, tmo_evt;
    logic [LANES-1:0] lane_mask;

    always_comb begin
        lane_mask = width_q ? MASK_WIDE : MASK_NARROW;
        wst_d = wst_q;
        wcnt_d = wcnt_q;
        ack_cyc = 1'b0;
        tmo_evt = 1'b0;
        case (wst_q)
            DLI_WAIT_IDLE: begin
                if (last_xfer) begin
                    wst_d = DLI_WAIT_ACK;
                    wcnt_d = RST_LIMIT;
                end
            end
            DLI_WAIT_ACK: begin
                if (tick && ack_seen) begin
                    ack_cyc = 1'b1;
                    wst_d = DLI_WAIT_DONE;
                end else if (tick && wcnt_q == limit_q) begin
                    tmo_evt = 1'b1;
                    wst_d = DLI_WAIT_DONE;
                end else if (tick) begin
                    wcnt_d = wcnt_q + 4'h1;
                end
            end
            DLI_WAIT_DONE: begin
                wst_d = DLI_WAIT_IDLE;
            end
            default: begin
                wst_d = DLI_WAIT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wst_q <= DLI_WAIT_IDLE;
            wcnt_q <= RST_LIMIT;
        end else begin
            wst_q <= wst_d;
            wcnt_q <= wcnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // error flags: a set in the clearing cycle wins
    logic err_sum_q, err_sum_d;
    logic ack_fault_q, ack_fault_d;
    logic cancel_q, cancel_d;
    logic tmo_q, tmo_d;
    logic tgt_err_q, tgt_err_d;
    logic par_q, par_d;
    logic [PAR_W-1:0] rxpar_q, rxpar_d;
    logic clr, set_fault, set_cancel, set_tgt, any_set;

    function automatic logic sticky(input logic q, input logic clear, input logic evt);
        return (q && !clear) || evt;
    endfunction : sticky

    always_comb begin
        clr = wr_stat0 && reg_wdata[BIT_ERR_SUM];
        set_fault = ack_cyc && ((din_s2_q & lane_mask) != lane_mask);
        set_cancel = xact_req && err_sum_q;
        set_tgt = ack_cyc && target_err;
        any_set = set_fault || set_cancel || tmo_evt || set_tgt || parity_err;
        err_sum_d = sticky(err_sum_q, clr, any_set);
        ack_fault_d = sticky(ack_fault_q, clr, set_fault);
        cancel_d = sticky(cancel_q, clr, set_cancel);
        tmo_d = sticky(tmo_q, clr, tmo_evt);
        tgt_err_d = sticky(tgt_err_q, clr, set_tgt);
        par_d = sticky(par_q, clr, parity_err);
        // parity capture is diagnostic only, so a clear leaves it
        rxpar_d = parity_err ? rx_parity : rxpar_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            err_sum_q <= 1'b0;
            ack_fault_q <= 1'b0;
            cancel_q <= 1'b0;
            tmo_q <= 1'b0;
            tgt_err_q <= 1'b0;
            par_q <= 1'b0;
            rxpar_q <= '0;
        end else begin
            err_sum_q <= err_sum_d;
            ack_fault_q <= ack_fault_d;
            cancel_q <= cancel_d;
            tmo_q <= tmo_d;
            tgt_err_q <= tgt_err_d;
            par_q <= par_d;
            rxpar_q <= rxpar_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port, transaction handshake and pin outputs
    logic [7:0] rdata_q, rdata_d;
    logic go_q, go_d, cncl_q, cncl_d, ackd_q, ackd_d;
    logic irq_q, irq_d;
    logic [LANES-1:0] dout_q, dout_d, doe_q, doe_d;
    logic prim_q, prim_d;

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL0: rdata_d = {enable_q, width_q, halt_wait_q, 3'h0, div_q};
                OFS_CTRL1: rdata_d = {irq_en_q, 3'h0, limit_q};
                OFS_STAT0: rdata_d = {err_sum_q, ack_fault_q, cancel_q, tmo_q,
                                      tgt_err_q, par_q, rxpar_q};
                // unmapped offsets read as zero
                default: rdata_d = RST_BYTE;
            endcase
        end
        go_d = xact_req && !err_sum_q && enable_q;
        cncl_d = set_cancel;
        ackd_d = ack_cyc || tmo_evt;
        irq_d = enable_q && irq_en_q && irq_s2_q;
        prim_d = enable_q;
        // idle command is all active lanes low; the engine owns them while driving and the link clock runs
        dout_d = (enable_q && eng_drive && run) ? (eng_data & lane_mask) : RST_BYTE;
        doe_d = (enable_q && (eng_drive || wst_q != DLI_WAIT_ACK)) ? lane_mask : RST_BYTE;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= RST_BYTE;
            go_q <= 1'b0;
            cncl_q <= 1'b0;
            ackd_q <= 1'b0;
            irq_q <= 1'b0;
            prim_q <= 1'b0;
            dout_q <= RST_BYTE;
            doe_q <= RST_BYTE;
        end else begin
            rdata_q <= rdata_d;
            go_q <= go_d;
            cncl_q <= cncl_d;
            ackd_q <= ackd_d;
            irq_q <= irq_d;
            prim_q <= prim_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign xact_go = go_q;
    assign xact_cancel = cncl_q;
    assign ack_done = ackd_q;
    assign target_irq_out = irq_q;
    assign error_irq = err_sum_q;
    assign pins_primary = prim_q;
    assign link_clock_oe = prim_q;
    assign link_data_out = dout_q;
    assign link_data_oe = doe_q;
endmodule : dli_ctrl_status
`default_nettype wire

// ### tb/dli_chk.sv
// assertions on the die link initiator register bank ports
// assumes binding to dli_ctrl_status with a single bus clock and srst
`timescale 1ns/1ps
`default_nettype none
module dli_chk
    import dli_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic stop_mode,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic xact_req,
    input wire logic last_xfer,
    input wire logic parity_err,
    input wire logic eng_drive,
    input wire logic target_irq_input,
    input wire logic [LANES-1:0] link_data_out,
    input wire logic [LANES-1:0] link_data_oe,
    input wire logic link_clock_out,
    input wire logic link_clock_oe,
    input wire logic pins_primary,
    input wire logic xact_go,
    input wire logic ack_done,
    input wire logic target_irq_out,
    input wire logic error_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_clr;
        reg_wr && reg_addr == OFS_STAT0 && reg_wdata[BIT_ERR_SUM];
    endsequence
    sequence s_quiet;
        !(parity_err || last_xfer || xact_req);
    endsequence
    property p_idle;
        pins_primary && !eng_drive && !$past(eng_drive) |-> link_data_out == 8'h00;
    endproperty
    property p_off;
        !pins_primary && $stable(pins_primary) |-> link_data_oe == 8'h00 && !link_clock_oe;
    endproperty
    property p_high;
        link_clock_out ##1 link_clock_out |=> !link_clock_out;
    endproperty
    property p_stop;
        $rose(stop_mode) |-> ##[1:5] !link_clock_out [*4];
    endproperty
    property p_irq;
        !target_irq_input [*4] |=> !target_irq_out;
    endproperty
    property p_cancel;
        xact_req && error_irq |-> ##1 !xact_go ##1 !xact_go;
    endproperty
    property p_set;
        parity_err |-> ##[1:2] error_irq;
    endproperty
    property p_keep;
        reg_wr && reg_addr == OFS_STAT0 && !reg_wdata[BIT_ERR_SUM] && error_irq |=> error_irq;
    endproperty
    property p_clr;
        s_clr ##0 s_quiet |-> ##[1:2] !error_irq;
    endproperty
    property p_ack;
        last_xfer |-> ##[1:80] ack_done;
    endproperty
    a_idle: assert property (p_idle) else $error("lanes not idle low");
    a_off: assert property (p_off) else $error("link pins used while off");
    a_high: assert property (p_high) else $error("clock high too long");
    a_stop: assert property (p_stop) else $error("clock runs in stop");
    a_irq: assert property (p_irq) else $error("irq without source");
    a_cancel: assert property (p_cancel) else $error("request started with error");
    a_set: assert property (p_set) else $error("summary not set");
    a_keep: assert property (p_keep) else $error("summary cleared by zero");
    a_clr: assert property (p_clr) else $error("summary not cleared");
    a_ack: assert property (p_ack) else $error("ack window never closed");
endmodule : dli_chk
////////////////////////////////////////////////////////////////////////////
bind dli_ctrl_status dli_chk dli_chk_i (.clk, .srst, .stop_mode, .reg_addr, .reg_wr,
    .reg_wdata, .xact_req, .last_xfer, .parity_err, .eng_drive, .target_irq_input,
    .link_data_out, .link_data_oe, .link_clock_out, .link_clock_oe, .pins_primary,
    .xact_go, .ack_done, .target_irq_out, .error_irq);
`default_nettype wire

// ### tb/dli_target_model.sv
// far side target: acknowledges after dly bus cycles, drives lanes while drv
// assumes last_xfer and ack_done pulses on the bus clock
`timescale 1ns/1ps
`default_nettype none
module dli_target_model
    import dli_pkg::*;
(
    input wire logic clk,
    input wire logic last_xfer,
    input wire logic ack_done,
    input wire logic drv,
    input wire logic [7:0] dly,
    input wire logic err,
    input wire logic bad,
    output logic ack_seen,
    output logic target_err,
    output logic [LANES-1:0] link_data_in
);
    int cnt = -1;
    // wait cycles before acknowledging; a huge dly forces a timeout
    always @(posedge clk) begin
        if (last_xfer) cnt <= dly;
        else if (ack_done) cnt <= -1;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    assign ack_seen = (cnt == 0);
    assign target_err = (cnt == 0) && err;
    // released lanes fall to the pull-down level; bad models one broken wire
    assign link_data_in = drv ? (bad ? 8'hef : 8'hff) : 8'h00;
endmodule : dli_target_model
`default_nettype wire

// ### tb/die_link_initiator_ctrl_status_tb_top.sv
// self-checking bench for the die link initiator register bank
// assumes dli_ctrl_status, the target model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module die_link_initiator_ctrl_status_tb_top;
    import dli_pkg::*;
    logic clk = 0, srst = 1, special_mode = 0, stop_mode = 0, wait_mode = 0, g;
    logic reg_wr = 0, reg_rd = 0, xact_req = 0, last_xfer = 0, eng_drive = 0;
    logic parity_err = 0, target_irq_input = 0, err = 0, bad = 0, drv = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, eng_data = 8'h00, dly = 8'h00;
    logic [1:0] rx_parity = 2'h0, par;
    logic [7:0] reg_rdata, link_data_out, link_data_oe, link_data_in;
    logic link_clock_out, link_clock_oe, pins_primary, xact_go, xact_cancel;
    logic ack_done, target_irq_out, error_irq, ack_seen, target_err;
    logic [31:0] rnd = 32'h395937b6;
    int fails = 0, num_checks = 0, n, h, lim;
    always #12.5 clk = ~clk;
    dli_ctrl_status dli_ctrl_status_i (.clk, .srst, .special_mode, .stop_mode,
        .wait_mode, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .xact_req,
        .last_xfer, .ack_seen, .target_err, .parity_err, .rx_parity, .eng_drive,
        .eng_data, .link_data_in, .target_irq_input, .link_data_out, .link_data_oe,
        .link_clock_out, .link_clock_oe, .pins_primary, .xact_go, .xact_cancel,
        .ack_done, .target_irq_out, .error_irq);
    dli_target_model dli_target_model_i (.clk, .last_xfer, .ack_done, .drv, .dly,
        .err, .bad, .ack_seen, .target_err, .link_data_in);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] stat_exp(input logic [4:0] f, input logic [1:0] p);
        return {|f, f, p};
    endfunction : stat_exp
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    task automatic count_hi(input int k);
        cyc(6);
        h = 0;
        repeat (k) begin
            cyc(1);
            h += link_clock_out;
        end
    endtask : count_hi
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        @(negedge clk);
        `CHK(reg_rdata & m, e)
    endtask : rd
    // n ends as the cycle count from the last transfer to the window close
    task automatic ack(input logic [7:0] d, input logic e, input logic b);
        dly = d;
        err = e;
        bad = b;
        drv = 1;
        cyc(4);
        last_xfer = 1;
        cyc(1);
        last_xfer = 0;
        n = 1;
        while (!ack_done && n < 200) begin
            cyc(1);
            n++;
        end
        `CHK(n < 200, 1'b1)
        drv = 0;
        cyc(3);
    endtask : ack
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    // whole run is under 500 cycles; twelve times that means a hang
    initial begin
        cyc(6000);
        fails++;
        print_verdict();
    end
    initial begin
        cyc(5);
        srst = 0;
        for (int a = 0; a < 4; a++) rd(a[2:0], 8'hff, 8'h00);
        `CHK({pins_primary, link_clock_oe, link_data_oe}, 10'h000)
        $display("test reset done");
        special_mode = 1;
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CTRL0, {1'b1, c[0], 4'h0, c[1:0]});
            rd(OFS_CTRL0, 8'he3, {1'b1, c[0], 4'h0, c[1:0]});
            count_hi(4 * (c + 1));
            `CHK(h, 4 * ((c + 1) / 2))
            if (c == 0) begin
                @(posedge clk);
                #1;
                `CHK(link_clock_out, 1'b1)
                cyc(1);
            end
            `CHK(link_data_oe, c[0] ? MASK_WIDE : MASK_NARROW)
            `CHK({pins_primary, link_data_out}, 9'h100)
            eng_drive = 1;
            eng_data = rnd[7:0];
            rnd = lfsr(rnd);
            cyc(2);
            `CHK(link_data_out, eng_data & (c[0] ? MASK_WIDE : MASK_NARROW))
            eng_drive = 0;
            wr(OFS_CTRL0, 8'h00);
            cyc(3);
            `CHK(pins_primary, 1'b0)
        end
        $display("test divider done");
        wr(OFS_CTRL0, 8'ha3);
        wait_mode = 1;
        count_hi(8);
        `CHK(h, 0)
        wr(OFS_CTRL0, 8'h83);
        count_hi(8);
        `CHK(h, 4)
        wait_mode = 0;
        stop_mode = 1;
        count_hi(8);
        `CHK(h, 0)
        stop_mode = 0;
        ack(8'h00, 1'b0, 1'b0);
        rd(OFS_STAT0, 8'hfc, 8'h00);
        ack(8'h08, 1'b0, 1'b0);
        `CHK(n <= 5, 1'b1)
        rd(OFS_STAT0, 8'hfc, stat_exp(5'b00100, 2'b00));
        wr(OFS_STAT0, 8'h80);
        wr(OFS_CTRL0, 8'h00);
        $display("test halt done");
        // lock the bank in normal mode with a random wait limit
        special_mode = 0;
        lim = 2 + rnd % 14;
        rnd = lfsr(rnd);
        wr(OFS_CTRL1, {4'h0, lim[3:0]});
        wr(OFS_CTRL0, 8'hc3);
        wr(OFS_CTRL0, 8'h20);
        rd(OFS_CTRL0, 8'he3, 8'he3);
        target_irq_input = 1;
        cyc(6);
        `CHK(target_irq_out, 1'b0)
        wr(OFS_CTRL1, 8'h80);
        rd(OFS_CTRL1, 8'h8f, {4'h8, lim[3:0]});
        `CHK(target_irq_out, 1'b1)
        target_irq_input = 0;
        $display("test lock done");
        ack(8'h00, 1'b0, 1'b0);
        ack(8'(lim * 4 - 6), 1'b0, 1'b0);
        rd(OFS_STAT0, 8'hfc, 8'h00);
        ack(8'hff, 1'b0, 1'b0);
        `CHK(n >= 4 * lim + 1 && n <= 4 * lim + 8, 1'b1)
        rd(OFS_STAT0, 8'hfc, stat_exp(5'b00100, 2'b00));
        `CHK(error_irq, 1'b1)
        wr(OFS_STAT0, 8'h7f);
        xact_req = 1;
        cyc(1);
        xact_req = 0;
        `CHK({xact_cancel, xact_go}, 2'b10)
        rd(OFS_STAT0, 8'hfc, stat_exp(5'b01100, 2'b00));
        par = rnd[1:0];
        rx_parity = par;
        parity_err = 1;
        cyc(1);
        parity_err = 0;
        rd(OFS_STAT0, 8'hff, stat_exp(5'b01101, par));
        wr(OFS_STAT0, 8'h80);
        rd(OFS_STAT0, 8'hff, stat_exp(5'b00000, par));
        ack(8'h00, 1'b0, 1'b1);
        rd(OFS_STAT0, 8'hff, stat_exp(5'b10000, par));
        wr(OFS_STAT0, 8'h80);
        ack(8'h00, 1'b1, 1'b0);
        rd(OFS_STAT0, 8'hff, stat_exp(5'b00010, par));
        wr(OFS_STAT0, 8'h80);
        xact_req = 1;
        cyc(1);
        xact_req = 0;
        g = xact_go;
        cyc(1);
        `CHK({g, xact_go}, 2'b10)
        $display("test errors done");
        print_verdict();
    end
endmodule : die_link_initiator_ctrl_status_tb_top
`default_nettype wire
